// ---- rtl/tpcf_cfg.svh ----
// Purpose: shared constants of the timer family
// Assumes: included by bare name
// Notes: definitions only
`ifndef TPCF_CFG_SVH
`define TPCF_CFG_SVH
// ==========================================================
// Field widths and counts
`define TPCF_DATA_W 32
`define TPCF_PSC_W 16
`define TPCF_DT_W 8
`define TPCF_SEL_W 3
`define TPCF_UNITS 6
`define TPCF_MAX_CH 4
// ==========================================================
// Reset values
`define TPCF_RST_CNT 32'h0000_0000
`define TPCF_RST_PSC 16'h0000
`define TPCF_RST_DT 8'h00
`endif

// ---- rtl/tpcf_pkg.sv ----
// Purpose: types of the timer family
// Assumes: tpcf_cfg.svh gives the widths
// Notes: no imports anywhere, names are scoped
`include "tpcf_cfg.svh"
package tpcf_pkg;
	// ==========================================================
	// Counting modes of one unit
	typedef enum logic [2:0]
	{
		cm_up,
		cm_down,
		cm_center,
		cm_encoder,
		cm_hall
	} tpcf_cnt_mode_t;
	// Slave behaviour towards the selected trigger
	typedef enum logic [1:0]
	{
		sl_off,
		sl_trig_start,
		sl_gated,
		sl_ext_clock
	} tpcf_slave_t;
	// Use of one channel
	typedef enum logic [1:0]
	{
		chm_capture,
		chm_compare,
		chm_pwm,
		chm_one_pulse
	} tpcf_ch_mode_t;
	// ==========================================================
	// Per-channel settings
	typedef struct packed
	{
		tpcf_ch_mode_t mode;
		logic [`TPCF_DATA_W-1:0] compare;
		logic polarity;
		logic dma_en;
	} tpcf_ch_cfg_t;
	// Per-unit settings
	typedef struct packed
	{
		logic enable;
		logic freeze_dbg;
		logic dma_upd;
		tpcf_cnt_mode_t count_mode;
		tpcf_slave_t slave;
		logic [`TPCF_SEL_W-1:0] trig_sel;
		logic [`TPCF_PSC_W-1:0] prescale;
		logic [`TPCF_DATA_W-1:0] reload;
		logic [`TPCF_DT_W-1:0] dead_time;
		tpcf_ch_cfg_t [`TPCF_MAX_CH-1:0] ch;
	} tpcf_unit_cfg_t;
	// Per-unit status, every field from a flip-flop
	typedef struct packed
	{
		logic [`TPCF_DATA_W-1:0] cnt;
		logic [`TPCF_MAX_CH-1:0][`TPCF_DATA_W-1:0] capture;
		logic [`TPCF_MAX_CH-1:0] cap_flag;
		logic update;
		logic dma_req;
		logic trgo;
	} tpcf_unit_sts_t;
endpackage

// ---- rtl/tpcf_timer_family.sv ----
// Purpose: six timer units: advanced, wide, narrow, basic, two complementary
// Assumes: one clock, inputs synchronous, config held by plain ports
// Notes: units share one parameterised core
// Contract
// - Advanced timer: three phases plus complements
// - Complementary pairs get programmable dead time
// - Advanced channels: capture, compare, PWM, one-pulse
// - PWM edge-aligned or centre-aligned up/down
// - Advanced PWM reaches zero and full duty
// - Counters freeze during debug halt, per unit
// - Linked timers trigger, gate or clock others
// - Wide timer: 32-bit up/down, 16-bit prescaler
// - Narrow timer: 16-bit up/down, 16-bit prescaler
// - Four-channel timers: four selectable channels each
// - Four-channel timers raise own DMA requests
// - Four-channel timers decode encoders and hall sensors
// - Basic timer: 16-bit up-only, one channel
// - Complementary timers: 16-bit up-only, one channel
// - Complementary timers: dead time and DMA
// - Any timer works as PWM or time base
`include "tpcf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Core of one timer unit
module tpcf_unit #(
	parameter int CNT_W = 16,
	parameter int NCH = 4,
	parameter bit UP_ONLY = 1'b0,
	parameter int NCOMPL = 0,
	parameter bit HAS_DMA = 1'b1,
	parameter bit HAS_ENC = 1'b0,
	parameter bit HAS_LINK = 1'b0
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_dbg_halt,
	input wire tpcf_pkg::tpcf_unit_cfg_t i_cfg,
	input wire logic [`TPCF_MAX_CH-1:0] i_ch_in,
	input wire logic [`TPCF_UNITS-1:0] i_trgo_all,
	output logic [`TPCF_MAX_CH-1:0] o_ch_out,
	output logic [`TPCF_MAX_CH-1:0] o_ch_out_n,
	output tpcf_pkg::tpcf_unit_sts_t o_sts
);
	localparam logic [CNT_W-1:0] ONE = CNT_W'(1);
	localparam logic [CNT_W-1:0] ZERO = CNT_W'(0);

	// Refuse shapes the logic cannot serve
	if (CNT_W < 1 || CNT_W > `TPCF_DATA_W || NCH < 1 || NCH > `TPCF_MAX_CH ||
		NCOMPL < 0 || NCOMPL > NCH)
	begin : g_bad_shape
		$error("tpcf_unit: unsupported width or channel count");
	end

	// Trigger select; out-of-range selects read as no trigger
	function automatic logic pick_trig(input logic [`TPCF_UNITS-1:0] v,
		input logic [`TPCF_SEL_W-1:0] s);
		pick_trig = (int'(s) < `TPCF_UNITS) ? v[s] : 1'b0;
	endfunction

	// ==========================================================
	// State
	logic [CNT_W-1:0] cnt_q, cnt_d; // Counter
	logic [`TPCF_PSC_W-1:0] psc_q, psc_d; // Prescaler count
	logic dir_down_q, dir_d; // Centre/encoder direction
	logic run_q, run_d; // Counter running
	logic en_q; // Enable, previous cycle
	logic trig_q; // Trigger, previous cycle
	logic [1:0] enc_q; // Encoder inputs, previous cycle
	logic [2:0] hall_q; // Hall inputs, previous cycle
	logic [`TPCF_MAX_CH-1:0] in_q; // Channel inputs, previous cycle
	logic upd_q, upd_d; // Update pulse
	logic dma_q; // DMA request pulse
	logic [`TPCF_MAX_CH-1:0] ref_q, ref_d; // Channel reference levels
	logic [`TPCF_MAX_CH-1:0] capf_q, capf_d; // Capture pulses
	logic [`TPCF_MAX_CH-1:0] ev_d; // Capture or match events
	logic [`TPCF_MAX_CH-1:0][CNT_W-1:0] cap_q; // Captured values
	logic [`TPCF_MAX_CH-1:0][`TPCF_DT_W-1:0] dt_q; // Dead-time counters
	logic [`TPCF_MAX_CH-1:0] out_q, outn_q; // Pin outputs
	logic [`TPCF_MAX_CH-1:0] dma_mask_w; // Per-channel DMA enables

	// ==========================================================
	// Decoding
	tpcf_pkg::tpcf_cnt_mode_t mode_w;
	wire logic [CNT_W-1:0] reload_w = i_cfg.reload[CNT_W-1:0];
	wire logic enc_mode_w = HAS_ENC && (i_cfg.count_mode == tpcf_pkg::cm_encoder);
	wire logic hall_mode_w = HAS_ENC && (i_cfg.count_mode == tpcf_pkg::cm_hall);
	assign mode_w = UP_ONLY ? tpcf_pkg::cm_up : i_cfg.count_mode;
	// trigger taken from a linked unit
	wire logic trig_w = HAS_LINK ? pick_trig(i_trgo_all, i_cfg.trig_sel) : 1'b0;
	wire logic trig_rise_w = trig_w & ~trig_q;
	wire logic slv_start_w = HAS_LINK && (i_cfg.slave == tpcf_pkg::sl_trig_start);
	wire logic slv_gate_w = HAS_LINK && (i_cfg.slave == tpcf_pkg::sl_gated);
	wire logic slv_clk_w = HAS_LINK && (i_cfg.slave == tpcf_pkg::sl_ext_clock);
	wire logic frozen_w = i_dbg_halt & i_cfg.freeze_dbg;
	wire logic start_w = i_cfg.enable & (slv_start_w ? trig_rise_w : ~en_q);
	wire logic active_w = run_q & ~frozen_w & (~slv_gate_w | trig_w);
	wire logic psc_in_w = slv_clk_w ? trig_rise_w : 1'b1;
	wire logic psc_hit_w = (psc_q == i_cfg.prescale);
	wire logic enc_step_w = enc_mode_w & |(enc_q ^ i_ch_in[1:0]);
	wire logic enc_up_w = ~(enc_q[0] ^ i_ch_in[1]);
	wire logic hall_chg_w = hall_mode_w & active_w & (hall_q != i_ch_in[2:0]);
	wire logic step_w = active_w & (enc_mode_w ? enc_step_w : (psc_in_w & psc_hit_w));
	wire logic at_top_w = (cnt_q >= reload_w);
	wire logic at_zero_w = (cnt_q == ZERO);
	wire logic [`TPCF_DATA_W:0] cnt_ext_w = (`TPCF_DATA_W+1)'(cnt_q);
	logic one_pulse_w;

	// Any one-pulse channel stops the counter at update
	always_comb
	begin
		one_pulse_w = 1'b0;
		for (int i = 0; i < NCH; i++)
			one_pulse_w = one_pulse_w | (i_cfg.ch[i].mode == tpcf_pkg::chm_one_pulse);
	end

	// ==========================================================
	// Next counter, direction and update
	always_comb
	begin
		cnt_d = cnt_q;
		dir_d = dir_down_q;
		upd_d = 1'b0;
		if (hall_chg_w)
		begin
			cnt_d = ZERO;
		end
		else if (step_w)
		begin
			case (mode_w)
				tpcf_pkg::cm_center:
				begin
					if (!dir_down_q && at_top_w)
					begin
						dir_d = 1'b1;
						upd_d = 1'b1;
						cnt_d = at_zero_w ? cnt_q : cnt_q - ONE;
					end
					else if (dir_down_q && at_zero_w)
					begin
						dir_d = 1'b0;
						upd_d = 1'b1;
						cnt_d = at_top_w ? cnt_q : cnt_q + ONE;
					end
					else
						cnt_d = dir_down_q ? cnt_q - ONE : cnt_q + ONE;
				end
				tpcf_pkg::cm_down:
				begin
					upd_d = at_zero_w;
					cnt_d = at_zero_w ? reload_w : cnt_q - ONE;
				end
				// Encoder follows the decoded direction
				tpcf_pkg::cm_encoder:
				begin
					dir_d = ~enc_up_w;
					if (enc_up_w)
					begin
						upd_d = at_top_w;
						cnt_d = at_top_w ? ZERO : cnt_q + ONE;
					end
					else
					begin
						upd_d = at_zero_w;
						cnt_d = at_zero_w ? reload_w : cnt_q - ONE;
					end
				end
				default:
				begin
					upd_d = at_top_w;
					cnt_d = at_top_w ? ZERO : cnt_q + ONE;
				end
			endcase
		end
	end

	// Prescaler and run control
	always_comb
	begin
		psc_d = psc_q;
		if (start_w)
			psc_d = `TPCF_RST_PSC;
		else if (active_w && psc_in_w && !enc_mode_w)
			psc_d = psc_hit_w ? `TPCF_RST_PSC : psc_q + 16'h0001;
		if (!i_cfg.enable)
			run_d = 1'b0;
		else if (start_w)
			run_d = 1'b1;
		else if (upd_d && one_pulse_w)
			run_d = 1'b0;
		else
			run_d = run_q;
	end

	// ==========================================================
	// Channel references, captures and events
	always_comb
	begin
		ref_d = ref_q;
		capf_d = '0;
		ev_d = '0;
		for (int i = 0; i < NCH; i++)
		begin
			case (i_cfg.ch[i].mode)
				// zero compare is off, above reload is on
				tpcf_pkg::chm_pwm:
					ref_d[i] = cnt_ext_w < {1'b0, i_cfg.ch[i].compare};
				tpcf_pkg::chm_one_pulse:
					ref_d[i] = run_q & (cnt_ext_w >= {1'b0, i_cfg.ch[i].compare});
				tpcf_pkg::chm_compare:
				begin
					ev_d[i] = step_w & (cnt_q == i_cfg.ch[i].compare[CNT_W-1:0]);
					ref_d[i] = ref_q[i] ^ ev_d[i];
				end
				default:
				begin
					ref_d[i] = 1'b0;
					capf_d[i] = (i_ch_in[i] & ~in_q[i]) | ((i == 0) & hall_chg_w);
					ev_d[i] = capf_d[i];
				end
			endcase
		end
	end

	// ==========================================================
	// Counter registers
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cnt_q <= CNT_W'(`TPCF_RST_CNT);
			psc_q <= `TPCF_RST_PSC;
			{dir_down_q, run_q, en_q, trig_q, upd_q, dma_q} <= 6'h00;
			{enc_q, hall_q, in_q} <= 9'h000;
		end
		else
		begin
			cnt_q <= cnt_d;
			psc_q <= psc_d;
			{dir_down_q, run_q, en_q, trig_q, upd_q} <= {dir_d, run_d, i_cfg.enable, trig_w, upd_d};
			// requests per unit on update or channel events
			dma_q <= HAS_DMA & ((upd_d & i_cfg.dma_upd) | |(ev_d & dma_mask_w));
			{enc_q, hall_q, in_q} <= {i_ch_in[1:0], i_ch_in[2:0], i_ch_in};
		end
	end

	// Gather the per-channel DMA enables into one mask
	always_comb
	begin
		for (int i = 0; i < `TPCF_MAX_CH; i++)
			dma_mask_w[i] = i_cfg.ch[i].dma_en;
	end

	// ==========================================================
	// Channel registers; dead time holds both sides idle after a change
	for (genvar i = 0; i < `TPCF_MAX_CH; i++)
	begin : g_ch
		wire logic pol_w = i_cfg.ch[i].polarity;
		wire logic idle_w = (dt_q[i] == `TPCF_RST_DT);
		always_ff @(posedge i_ref_clk or posedge i_rst)
		begin
			if (i_rst)
			begin
				{ref_q[i], capf_q[i], out_q[i], outn_q[i]} <= 4'h0;
				cap_q[i] <= ZERO;
				dt_q[i] <= `TPCF_RST_DT;
			end
			else if (i < NCH)
			begin
				ref_q[i] <= ref_d[i];
				capf_q[i] <= capf_d[i];
				if (capf_d[i])
					cap_q[i] <= cnt_q;
				// reload the gap on every reference change of a complementary channel
				if (i < NCOMPL && ref_d[i] != ref_q[i])
					dt_q[i] <= i_cfg.dead_time;
				else if (!idle_w)
					dt_q[i] <= dt_q[i] - 8'h01;
				out_q[i] <= pol_w ^ (ref_q[i] & idle_w);
				outn_q[i] <= (i < NCOMPL) ? pol_w ^ (~ref_q[i] & idle_w) : 1'b0;
			end
		end
	end

	assign o_ch_out = out_q;
	assign o_ch_out_n = outn_q;
	assign o_sts.cnt = `TPCF_DATA_W'(cnt_q);
	assign o_sts.cap_flag = capf_q;
	assign o_sts.update = upd_q;
	assign o_sts.dma_req = dma_q;
	assign o_sts.trgo = upd_q;
	for (genvar i = 0; i < `TPCF_MAX_CH; i++)
	begin : g_cap
		assign o_sts.capture[i] = `TPCF_DATA_W'(cap_q[i]);
	end

	// ==========================================================
	// Checks
	a_psc_spacing: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		step_w && !enc_mode_w && i_cfg.prescale != 16'h0000 |=> !step_w)
		else $error("prescaler ticked on consecutive cycles");
	a_up_wrap: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		step_w && mode_w == tpcf_pkg::cm_up && at_top_w && !hall_chg_w
		|=> cnt_q == ZERO && upd_q)
		else $error("up count did not wrap with update");
	a_down_wrap: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		step_w && mode_w == tpcf_pkg::cm_down && at_zero_w
		|=> cnt_q == $past(reload_w) && upd_q)
		else $error("down count did not reload with update");
	a_freeze_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		frozen_w |=> $stable(cnt_q))
		else $error("counter moved while frozen");
	a_center_turn: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		step_w && mode_w == tpcf_pkg::cm_center && !dir_down_q && at_top_w && !at_zero_w
		|=> dir_down_q && cnt_q == $past(cnt_q) - ONE)
		else $error("centre count did not turn at top");
	a_duty_off: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_cfg.ch[0].mode == tpcf_pkg::chm_pwm && i_cfg.ch[0].compare == 32'h0000_0000
		|=> !ref_q[0])
		else $error("zero duty produced an active level");
	a_duty_full: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_cfg.ch[0].mode == tpcf_pkg::chm_pwm && cnt_q <= reload_w &&
		{1'b0, i_cfg.ch[0].compare} > (`TPCF_DATA_W+1)'(reload_w) |=> ref_q[0])
		else $error("full duty dropped");
	a_dead_gap: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		NCOMPL > 0 && dt_q[0] != `TPCF_RST_DT
		|=> o_ch_out[0] == $past(i_cfg.ch[0].polarity) &&
		o_ch_out_n[0] == $past(i_cfg.ch[0].polarity))
		else $error("output active inside dead time");
	a_capture_val: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		capf_d[0] |=> capf_q[0] && cap_q[0] == $past(cnt_q) ##1 !capf_q[0] || $past(capf_d[0]))
		else $error("capture value or pulse wrong");
	a_dma_update: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		HAS_DMA && upd_d && i_cfg.dma_upd |=> dma_q && upd_q)
		else $error("update did not raise a DMA request");
	a_one_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		upd_d && one_pulse_w && !start_w |=> !run_q ##1 !upd_q)
		else $error("one-pulse counter kept running");
endmodule // tpcf_unit

// ==========================================================
// Family top: six units with the trigger link between them
module tpcf_timer_family (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_dbg_halt,
	input wire tpcf_pkg::tpcf_unit_cfg_t [`TPCF_UNITS-1:0] i_cfg,
	input wire logic [`TPCF_UNITS-1:0][`TPCF_MAX_CH-1:0] i_ch_in,
	output logic [`TPCF_UNITS-1:0][`TPCF_MAX_CH-1:0] o_ch_out,
	output logic [`TPCF_UNITS-1:0][`TPCF_MAX_CH-1:0] o_ch_out_n,
	output tpcf_pkg::tpcf_unit_sts_t [`TPCF_UNITS-1:0] o_sts
);
	// Unit order: advanced, wide, narrow, basic, complementary a, b
	// wide unit is 32 bits, others 16
	localparam int W_A[`TPCF_UNITS] = '{16, 32, 16, 16, 16, 16};
	// four channels on the first three units
	localparam int N_A[`TPCF_UNITS] = '{4, 4, 4, 1, 1, 1};
	// basic and complementary units count up only
	localparam bit U_A[`TPCF_UNITS] = '{0, 0, 0, 1, 1, 1};
	// three complementary phases on the advanced unit
	localparam int C_A[`TPCF_UNITS] = '{3, 0, 0, 0, 1, 1};
	// DMA everywhere but the basic unit
	localparam bit D_A[`TPCF_UNITS] = '{1, 1, 1, 0, 1, 1};
	// encoder and hall decode on the two general units
	localparam bit E_A[`TPCF_UNITS] = '{0, 1, 1, 0, 0, 0};
	// link among the advanced and four-channel units
	localparam bit L_A[`TPCF_UNITS] = '{1, 1, 1, 0, 0, 0};

	logic [`TPCF_UNITS-1:0] trgo_w; // Update triggers of all units

	// every unit runs as time base or PWM source
	for (genvar u = 0; u < `TPCF_UNITS; u++)
	begin : g_unit
		assign trgo_w[u] = o_sts[u].trgo;
		// narrow unit is the 16-bit up/down variant
		tpcf_unit #(
			.CNT_W(W_A[u]),
			.NCH(N_A[u]),
			.UP_ONLY(U_A[u]),
			.NCOMPL(C_A[u]),
			.HAS_DMA(D_A[u]),
			.HAS_ENC(E_A[u]),
			.HAS_LINK(L_A[u])
		) u_unit (
			.i_ref_clk(i_ref_clk),
			.i_rst(i_rst),
			.i_dbg_halt(i_dbg_halt),
			.i_cfg(i_cfg[u]),
			.i_ch_in(i_ch_in[u]),
			.i_trgo_all(trgo_w),
			.o_ch_out(o_ch_out[u]),
			.o_ch_out_n(o_ch_out_n[u]),
			.o_sts(o_sts[u])
		);
	end
endmodule // tpcf_timer_family
`default_nettype wire

// ---- sim/tpcf_enc_model.sv ----
// Purpose: quadrature encoder on the far side of a timer
// Assumes: one step request at a time, a few cycles apart
// Notes: A leads B when stepping forward
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Encoder model
module tpcf_enc_model (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_step, // One phase step per cycle high
	input wire logic i_fwd, // Step direction
	output logic o_a, // Phase A
	output logic o_b // Phase B
);
	logic [1:0] phase_q; // Position within one quadrature cycle
	assign o_a = phase_q[1] ^ phase_q[0];
	assign o_b = phase_q[1];
	// One phase per step, so only one line ever changes at a time
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			phase_q <= 2'h0;
		else if (i_step)
			phase_q <= i_fwd ? phase_q + 2'h1 : phase_q - 2'h1;
	end
endmodule // tpcf_enc_model
`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: self-checking bench for the timer family
// Assumes: 25 MHz clock, settings held on plain ports
// Notes: each group of scenarios starts from a fresh reset, except the one-pulse group
`include "tpcf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// Compare and count; exp is widened to the design value
`define CHK(what, exp, got) \
	begin \
		checks++; \
		if ((got) !== (exp)) \
		begin \
			n_mismatch++; \
			$display("unexpected %s: expected %0h seen %0h", what, exp, got); \
		end \
	end

// ==========================================================
// Bench top
module tb;
	logic ref_clk; // 25 MHz reference
	logic rst; // Active-high reset
	logic dbg_halt; // Debugger halt
	logic enc_step; // Encoder step strobe
	logic enc_fwd; // Encoder direction
	logic enc_a; // Encoder phase A
	logic enc_b; // Encoder phase B
	int n_mismatch; // Mismatches
	int checks; // Comparisons
	int n, gap, seen, hi, hin; // Scenario scratch
	logic [31:0] base, b; // Snapshots of counts
	tpcf_pkg::tpcf_unit_cfg_t [`TPCF_UNITS-1:0] cfg; // Per-unit settings
	logic [`TPCF_UNITS-1:0][`TPCF_MAX_CH-1:0] ch_drv, ch_in; // Channel inputs
	logic [`TPCF_UNITS-1:0][`TPCF_MAX_CH-1:0] ch_out, ch_out_n; // Channel pins
	tpcf_pkg::tpcf_unit_sts_t [`TPCF_UNITS-1:0] sts; // Status

	tpcf_timer_family DUT (
		.i_ref_clk(ref_clk), .i_rst(rst), .i_dbg_halt(dbg_halt), .i_cfg(cfg),
		.i_ch_in(ch_in), .o_ch_out(ch_out), .o_ch_out_n(ch_out_n), .o_sts(sts)
	);
	tpcf_enc_model u_enc (
		.i_ref_clk(ref_clk), .i_rst(rst), .i_step(enc_step), .i_fwd(enc_fwd),
		.o_a(enc_a), .o_b(enc_b)
	);

	// Encoder phases replace the bench drive on the wide timer
	always_comb
	begin
		ch_in = ch_drv;
		ch_in[1][1:0] = {enc_b, enc_a};
	end

	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// ==========================================================
	// Access tasks
	// Just past an edge: outputs settled, inputs may change
	task automatic tick(input int k = 1);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask

	task automatic restart();
		cfg = '0;
		ch_drv = '0;
		dbg_halt = 1'b0;
		enc_step = 1'b0;
		enc_fwd = 1'b1;
		rst = 1'b1;
		tick(6);
		rst = 1'b0;
		tick();
	endtask

	task automatic run(input int u, input tpcf_pkg::tpcf_cnt_mode_t m, input logic [7:0] psc,
		input logic [7:0] rel);
		cfg[u].count_mode = m;
		cfg[u].prescale = {8'h00, psc};
		cfg[u].reload = {24'h00_0000, rel};
		cfg[u].trig_sel = 3'h7;
		cfg[u].enable = 1'b1;
	endtask

	// Bounded wait for a count value
	task automatic wait_cnt(input int u, input logic [7:0] v);
		int w;
		w = 0;
		while (sts[u].cnt !== {24'h00_0000, v} && w < 300)
		begin
			tick();
			w++;
		end
		`CHK("count reached", v, sts[u].cnt);
	endtask

	// Count sequence with update and DMA pulse masks
	task automatic seq(input int u, input logic [7:0] v0, input logic [7:0] e[$],
		input logic [15:0] um, input logic [15:0] dm);
		wait_cnt(u, v0);
		foreach (e[i])
		begin
			tick();
			`CHK("count", e[i], sts[u].cnt);
			`CHK("update", um[i], sts[u].update);
			`CHK("dma", dm[i], sts[u].dma_req);
		end
	endtask

	// Wait long enough for a step to reach the counter
	task automatic enc(input int k, input logic fwd);
		repeat (k)
		begin
			enc_fwd = fwd;
			enc_step = 1'b1;
			tick();
			enc_step = 1'b0;
			tick(4);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Watchdog, well beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		wrap_up();
	end

	// ==========================================================
	// Scenarios
	initial
	begin
		n_mismatch = 0;
		checks = 0;
		restart();
		// Counting shapes on five units at once
		cfg[1].dma_upd = 1'b1;
		cfg[3].dma_upd = 1'b1;
		run(0, tpcf_pkg::cm_center, 8'h00, 8'h03);
		run(1, tpcf_pkg::cm_down, 8'h00, 8'h03);
		run(2, tpcf_pkg::cm_up, 8'h02, 8'h02);
		run(3, tpcf_pkg::cm_up, 8'h00, 8'h02);
		run(4, tpcf_pkg::cm_down, 8'h00, 8'h02);
		seq(3, 8'h02, '{8'h00, 8'h01, 8'h02, 8'h00}, 16'h0009, 16'h0000);
		seq(1, 8'h01, '{8'h00, 8'h03, 8'h02}, 16'h0002, 16'h0002);
		seq(2, 8'h01, '{8'h01, 8'h01, 8'h02, 8'h02, 8'h02, 8'h00}, 16'h0020, 16'h0000);
		seq(0, 8'h03, '{8'h02, 8'h01, 8'h00, 8'h01, 8'h02, 8'h03}, 16'h0009, 16'h0000);
		seq(4, 8'h02, '{8'h00, 8'h01}, 16'h0001, 16'h0000);
		// Duty extremes, phase pairs and dead time
		restart();
		cfg[0].ch[0].mode = tpcf_pkg::chm_pwm;
		cfg[0].ch[1].mode = tpcf_pkg::chm_pwm;
		cfg[0].ch[2].mode = tpcf_pkg::chm_pwm;
		cfg[0].ch[1].compare = 32'h0000_0005;
		cfg[0].ch[2].compare = 32'h0000_0002;
		cfg[4].ch[0].mode = tpcf_pkg::chm_pwm;
		cfg[4].ch[0].compare = 32'h0000_0005;
		cfg[4].dead_time = 8'h02;
		run(0, tpcf_pkg::cm_up, 8'h00, 8'h04);
		run(4, tpcf_pkg::cm_up, 8'h00, 8'h09);
		tick(12);
		hi = 0;
		hin = 0;
		repeat (10)
		begin
			tick();
			`CHK("zero duty", 1'b0, ch_out[0][0]);
			`CHK("full duty", 1'b1, ch_out[0][1]);
			hi += ch_out[0][2];
			hin += ch_out_n[0][2];
		end
		`CHK("duty highs", 4, hi);
		`CHK("complement highs", 6, hin);
		gap = 0;
		seen = 0;
		repeat (40)
		begin
			tick();
			`CHK("overlap", 1'b0, ch_out[4][0] & ch_out_n[4][0]);
			if (ch_out[4][0] === 1'b0 && ch_out_n[4][0] === 1'b0)
				gap++;
			else
			begin
				if (seen != 0 && gap != 0) `CHK("dead gap", 2, gap);
				seen = 1;
				gap = 0;
			end
		end
		// Debug freeze on one unit only, then a capture
		restart();
		cfg[2].freeze_dbg = 1'b1;
		run(0, tpcf_pkg::cm_up, 8'h00, 8'hff);
		run(2, tpcf_pkg::cm_up, 8'h00, 8'hff);
		tick(5);
		dbg_halt = 1'b1;
		tick(2);
		base = sts[2].cnt;
		b = sts[0].cnt;
		tick(5);
		`CHK("frozen", base, sts[2].cnt);
		`CHK("not frozen", b + 32'h0000_0005, sts[0].cnt);
		dbg_halt = 1'b0;
		tick(3);
		`CHK("resumed", 1'b1, sts[2].cnt > base);
		base = sts[2].cnt;
		ch_drv[2][1] = 1'b1;
		n = 0;
		while (sts[2].cap_flag[1] !== 1'b1 && n < 5)
		begin
			tick();
			n++;
		end
		`CHK("capture flag", 1'b1, sts[2].cap_flag[1]);
		`CHK("capture value", 1'b1, sts[2].capture[1] - base <= 32'h0000_0002);
		tick();
		`CHK("flag pulse", 1'b0, sts[2].cap_flag[1]);
		// One-pulse on the basic unit: counter stops at its first wrap
		cfg[3].ch[0].mode = tpcf_pkg::chm_one_pulse;
		cfg[3].ch[0].compare = 32'h0000_0002;
		run(3, tpcf_pkg::cm_up, 8'h00, 8'h04);
		tick(16);
		`CHK("one-pulse stop", 32'h0000_0000, sts[3].cnt);
		`CHK("one-pulse pin", 1'b0, ch_out[3][0]);
		// Encoder both ways, then one timer clocked by another
		restart();
		run(1, tpcf_pkg::cm_encoder, 8'h00, 8'hff);
		enc(4, 1'b1);
		`CHK("encoder forward", 32'h0000_0004, sts[1].cnt);
		enc(2, 1'b0);
		`CHK("encoder back", 32'h0000_0002, sts[1].cnt);
		run(2, tpcf_pkg::cm_up, 8'h00, 8'hff);
		cfg[2].slave = tpcf_pkg::sl_ext_clock;
		cfg[2].trig_sel = 3'h3;
		tick(10);
		`CHK("link idle", 8'h00, sts[2].cnt);
		run(3, tpcf_pkg::cm_up, 8'h00, 8'h05);
		for (int k = 1; k <= 4; k++)
		begin
			n = 0;
			while (sts[3].trgo !== 1'b1 && n < 20)
			begin
				tick();
				n++;
			end
			tick(4);
			`CHK("linked count", k, sts[2].cnt);
		end
		wrap_up();
	end
endmodule // tb
`default_nettype wire
